/* File: rtl/swotp_pkg.sv */
// Package of constants and carrier types for the single-wire OTP selector reader
package swotp_pkg;
   localparam int SWOTP_MEM_BYTES = 192;
   localparam int SWOTP_PAGE_BYTES = 32;
   localparam logic [7:0] SWOTP_LAST_ADDR = 8'hBF;
   localparam logic [4:0] SWOTP_PAGE_LAST = 5'h1F;
   localparam logic [7:0] SWOTP_CMD_READ_ID = 8'h33;
   localparam logic [7:0] SWOTP_CMD_MATCH_ID = 8'h55;
   localparam logic [7:0] SWOTP_CMD_SEARCH_ID = 8'hF0;
   localparam logic [7:0] SWOTP_CMD_SKIP_ID = 8'hCC;
   localparam logic [7:0] SWOTP_CMD_READ_PAGE = 8'hC3;
   localparam logic [7:0] SWOTP_CMD_READ_FIELD = 8'hF0;
   localparam logic [7:0] SWOTP_CMD_WRITE_DATA = 8'h0F;
   localparam logic [7:0] SWOTP_CMD_READ_STAT = 8'hAA;
   localparam logic [7:0] SWOTP_CMD_WRITE_STAT = 8'h55;
   localparam logic [7:0] SWOTP_CRC_POLY_REV = 8'h8C;
   localparam logic [7:0] SWOTP_CRC_INIT = 8'h00;
   localparam logic [7:0] SWOTP_ERASED_BYTE = 8'hFF;
   localparam logic [5:0] SWOTP_ID_LAST_BIT = 6'h3F;
   localparam logic [2:0] SWOTP_BYTE_LAST_BIT = 3'h7;
   localparam int SWOTP_FIFO_DEPTH = 4;
   localparam int SWOTP_FIFO_WIDTH = 8;

   // One time slot as seen by the slot decoder: write bit from host or read request
   typedef struct packed {
      logic is_read;
      logic wbit;
   } swotp_slot_t;

   // Family code, serial and check byte, family code in the low byte
   typedef struct packed {
      logic [7:0] crc;
      logic [47:0] serial;
      logic [7:0] family;
   } swotp_ident_t;

   typedef enum logic [3:0] {
      SWOTP_IDLE, SWOTP_ID_CMD, SWOTP_ID_READ, SWOTP_ID_MATCH, SWOTP_ID_SEARCH,
      SWOTP_FN_CMD, SWOTP_ADDR_LO, SWOTP_ADDR_HI, SWOTP_HDR_CRC, SWOTP_DATA,
      SWOTP_PAGE_CRC, SWOTP_ONES, SWOTP_DEAD
   } swotp_state_t;
endpackage

/* File: rtl/swotp_fifo.sv */
// Small valid/ready FIFO carrying bytes toward the line serialiser
`timescale 1ns/1ps
`default_nettype none
module swotp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (ce && push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else if (ce) begin
         if (flush) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
         end else begin
            if (push) begin
               wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
               rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/swotp_reader.sv */
// Slave-side command logic of the single-wire OTP selector reader
`timescale 1ns/1ps
`default_nettype none
module swotp_reader
   import swotp_pkg::*;
#(
   parameter logic [7:0] FAMILY_CODE = 8'hA5, // Arbitrary value
   parameter logic [47:0] SERIAL_NUM = 48'h0123_4567_89AB // Arbitrary value
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic line_reset,
   input wire logic slot_valid,
   input wire swotp_slot_t slot,
   output logic presence_req,
   output logic line_o,
   output logic line_oe,
   output logic slot_done,
   output logic selected,
   output logic [7:0] mem_rd_addr,
   input wire logic [7:0] mem_rd_data,
   output logic [7:0] last_cmd
);
   // ======================================================================
   // Helpers
   function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
      logic fb;
      fb = c[0] ^ b;
      crc_bit = (c >> 1) ^ (fb ? SWOTP_CRC_POLY_REV : 8'h00);
   endfunction

   function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = crc_bit(r, d[i]);
      end
      crc_byte = r;
   endfunction

   function automatic logic is_page_end(input logic [7:0] a);
      is_page_end = (a[4:0] == SWOTP_PAGE_LAST);
   endfunction

   // ======================================================================
   // Identity
   logic [63:0] ident;
   assign ident[7:0] = FAMILY_CODE;
   assign ident[55:8] = SERIAL_NUM;
   assign ident[63:56] = crc_id(FAMILY_CODE, SERIAL_NUM);

   function automatic logic [7:0] crc_id(input logic [7:0] f, input logic [47:0] s);
      logic [7:0] r;
      r = crc_byte(SWOTP_CRC_INIT, f);
      for (int i = 0; i < 6; i++) begin
         r = crc_byte(r, s[i*8 +: 8]);
      end
      crc_id = r;
   endfunction

   // ======================================================================
   // State
   swotp_state_t st_r;
   logic [7:0] sh_r;
   logic [2:0] bcnt_r;
   logic [5:0] idx_r;
   logic [1:0] sphase_r;
   logic [7:0] crc_r;
   logic [7:0] addr_r;
   logic match_ok_r;
   logic fill_pend_r;
   logic tx_busy_r;
   logic [7:0] tx_r;

   // Read path FIFO: memory bytes wait here until the serialiser takes them
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [7:0] fifo_out_data;
   logic fifo_flush;

   logic wslot;
   logic rslot;
   logic [7:0] sh_in;
   assign wslot = slot_valid && !slot.is_read;
   assign rslot = slot_valid && slot.is_read;
   assign sh_in = {slot.wbit, sh_r[7:1]};
   assign fifo_flush = line_reset;
   assign fifo_in_valid = fill_pend_r && (st_r == SWOTP_DATA);
   assign fifo_out_ready = (st_r == SWOTP_DATA) && !tx_busy_r;

   swotp_fifo #(
      .WIDTH(SWOTP_FIFO_WIDTH),
      .DEPTH(SWOTP_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .flush(fifo_flush),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(mem_rd_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // ======================================================================
   // Read address feeding the FIFO, one fetch per accepted byte
   logic [7:0] fetch_r;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fetch_r <= 8'h00;
         fill_pend_r <= 1'b0;
      end else if (ce) begin
         if (line_reset || st_r != SWOTP_DATA) begin
            fetch_r <= addr_r;
            fill_pend_r <= (st_r == SWOTP_HDR_CRC || st_r == SWOTP_PAGE_CRC) && !line_reset;
         end else if (fill_pend_r && fifo_in_ready) begin
            // Stop prefetching at the page end; the check byte follows
            fill_pend_r <= !is_page_end(fetch_r);
            fetch_r <= fetch_r + 8'h01;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mem_rd_addr <= 8'h00;
      end else if (ce) begin
         // Always the address of the byte pushed in the coming cycle
         if (line_reset || st_r != SWOTP_DATA) begin
            mem_rd_addr <= addr_r;
         end else if (fill_pend_r && fifo_in_ready) begin
            mem_rd_addr <= fetch_r + 8'h01;
         end else begin
            mem_rd_addr <= fetch_r;
         end
      end
   end

   // ======================================================================
   // Command sequencer
   logic drive_zero;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_r <= SWOTP_IDLE;
         sh_r <= 8'h00;
         bcnt_r <= 3'h0;
         idx_r <= 6'h00;
         sphase_r <= 2'h0;
         crc_r <= SWOTP_CRC_INIT;
         addr_r <= 8'h00;
         match_ok_r <= 1'b0;
         selected <= 1'b0;
         last_cmd <= 8'h00;
         tx_busy_r <= 1'b0;
         tx_r <= 8'h00;
         drive_zero <= 1'b0;
         slot_done <= 1'b0;
         presence_req <= 1'b0;
      end else if (ce) begin
         slot_done <= slot_valid;
         presence_req <= line_reset;
         if (line_reset) begin
            // Every transaction starts here and clears selection
            st_r <= SWOTP_ID_CMD;
            selected <= 1'b0;
            bcnt_r <= 3'h0;
            idx_r <= 6'h00;
            sphase_r <= 2'h0;
            crc_r <= SWOTP_CRC_INIT;
            tx_busy_r <= 1'b0;
            drive_zero <= 1'b0;
         end else begin
            case (st_r)
               SWOTP_ID_CMD: begin
                  if (wslot) begin
                     sh_r <= sh_in;
                     bcnt_r <= bcnt_r + 3'h1;
                     if (bcnt_r == SWOTP_BYTE_LAST_BIT) begin
                        idx_r <= 6'h00;
                        sphase_r <= 2'h0;
                        match_ok_r <= 1'b1;
                        case (sh_in)
                           SWOTP_CMD_READ_ID: st_r <= SWOTP_ID_READ;
                           SWOTP_CMD_MATCH_ID: st_r <= SWOTP_ID_MATCH;
                           SWOTP_CMD_SEARCH_ID: st_r <= SWOTP_ID_SEARCH;
                           SWOTP_CMD_SKIP_ID: begin
                              selected <= 1'b1;
                              st_r <= SWOTP_FN_CMD;
                           end
                           default: st_r <= SWOTP_DEAD;
                        endcase
                     end
                  end
               end
               SWOTP_ID_READ: begin
                  if (rslot) begin
                     idx_r <= idx_r + 6'h01;
                     if (idx_r == SWOTP_ID_LAST_BIT) begin
                        selected <= 1'b1;
                        st_r <= SWOTP_FN_CMD;
                     end
                  end
               end
               SWOTP_ID_MATCH: begin
                  if (wslot) begin
                     idx_r <= idx_r + 6'h01;
                     if (idx_r == SWOTP_ID_LAST_BIT) begin
                        // All 64 bits must agree to become selected
                        if (match_ok_r && slot.wbit == ident[idx_r]) begin
                           selected <= 1'b1;
                           st_r <= SWOTP_FN_CMD;
                        end else begin
                           st_r <= SWOTP_DEAD;
                        end
                     end else if (slot.wbit != ident[idx_r]) begin
                        match_ok_r <= 1'b0;
                     end
                  end
               end
               SWOTP_ID_SEARCH: begin
                  if (slot_valid) begin
                     if (sphase_r == 2'h2) begin
                        sphase_r <= 2'h0;
                        if (slot.wbit != ident[idx_r]) begin
                           st_r <= SWOTP_DEAD;
                        end else if (idx_r == SWOTP_ID_LAST_BIT) begin
                           selected <= 1'b1;
                           st_r <= SWOTP_FN_CMD;
                        end else begin
                           idx_r <= idx_r + 6'h01;
                        end
                     end else begin
                        sphase_r <= sphase_r + 2'h1;
                     end
                  end
               end
               SWOTP_FN_CMD: begin
                  if (wslot) begin
                     sh_r <= sh_in;
                     bcnt_r <= bcnt_r + 3'h1;
                     if (bcnt_r == SWOTP_BYTE_LAST_BIT) begin
                        last_cmd <= sh_in;
                        crc_r <= crc_byte(SWOTP_CRC_INIT, sh_in);
                        if (!selected) begin
                           st_r <= SWOTP_DEAD;
                        end else if (sh_in == SWOTP_CMD_READ_PAGE) begin
                           st_r <= SWOTP_ADDR_LO;
                        end else begin
                           st_r <= SWOTP_DEAD;
                        end
                     end
                  end
               end
               SWOTP_ADDR_LO, SWOTP_ADDR_HI: begin
                  if (wslot) begin
                     sh_r <= sh_in;
                     bcnt_r <= bcnt_r + 3'h1;
                     if (bcnt_r == SWOTP_BYTE_LAST_BIT) begin
                        crc_r <= crc_byte(crc_r, sh_in);
                        if (st_r == SWOTP_ADDR_LO) begin
                           addr_r <= sh_in;
                           st_r <= SWOTP_ADDR_HI;
                        end else begin
                           if (sh_in != 8'h00 || addr_r > SWOTP_LAST_ADDR) begin
                              addr_r <= SWOTP_ERASED_BYTE;
                           end
                           st_r <= SWOTP_HDR_CRC;
                           tx_r <= crc_byte(crc_r, sh_in);
                        end
                     end
                  end
               end
               SWOTP_HDR_CRC, SWOTP_PAGE_CRC: begin
                  if (rslot) begin
                     tx_r <= {1'b1, tx_r[7:1]};
                     bcnt_r <= bcnt_r + 3'h1;
                     if (bcnt_r == SWOTP_BYTE_LAST_BIT) begin
                        crc_r <= SWOTP_CRC_INIT;
                        // Address already points at the next byte to stream
                        st_r <= (addr_r > SWOTP_LAST_ADDR) ? SWOTP_ONES : SWOTP_DATA;
                     end
                  end
               end
               SWOTP_DATA: begin
                  if (!tx_busy_r && fifo_out_valid) begin
                     tx_r <= fifo_out_data;
                     tx_busy_r <= 1'b1;
                     bcnt_r <= 3'h0;
                  end else if (tx_busy_r && rslot) begin
                     tx_r <= {1'b1, tx_r[7:1]};
                     crc_r <= crc_bit(crc_r, tx_r[0]);
                     bcnt_r <= bcnt_r + 3'h1;
                     if (bcnt_r == SWOTP_BYTE_LAST_BIT) begin
                        tx_busy_r <= 1'b0;
                        addr_r <= addr_r + 8'h01;
                        if (is_page_end(addr_r)) begin
                           st_r <= SWOTP_PAGE_CRC;
                           tx_r <= crc_bit(crc_r, tx_r[0]);
                        end
                     end
                  end
               end
               default: begin
               end
            endcase
            // Line pull for the next read slot, computed one cycle ahead
            case (st_r)
               SWOTP_ID_READ: drive_zero <= !ident[idx_r];
               SWOTP_ID_SEARCH: drive_zero <= (sphase_r == 2'h0) ? !ident[idx_r] :
                                              (sphase_r == 2'h1) ? ident[idx_r] : 1'b0;
               SWOTP_HDR_CRC, SWOTP_PAGE_CRC: drive_zero <= !tx_r[0];
               // Head of the FIFO sets up the pull before it is loaded
               SWOTP_DATA: drive_zero <= tx_busy_r ? !tx_r[0] :
                                         (fifo_out_valid && !fifo_out_data[0]);
               default: drive_zero <= 1'b0;
            endcase
         end
      end
   end

   // ======================================================================
   // Open-drain pin: only ever pulls low
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         line_o <= 1'b0;
         line_oe <= 1'b0;
      end else if (ce) begin
         line_o <= 1'b0;
         line_oe <= drive_zero && !line_reset;
      end
   end
endmodule
`default_nettype wire

/* File: tb/swotp_reader_properties.sv */
// Concurrent checks on the ports of the single-wire reader
`timescale 1ns/1ps
`default_nettype none
module swotp_reader_properties
   import swotp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic line_reset,
   input wire logic slot_valid,
   input wire swotp_slot_t slot,
   input wire logic presence_req,
   input wire logic line_o,
   input wire logic line_oe,
   input wire logic slot_done,
   input wire logic selected,
   input wire logic [7:0] mem_rd_addr,
   input wire logic [7:0] mem_rd_data,
   input wire logic [7:0] last_cmd
);
   logic [2:0] quiet_r;
   // ========
   // Cycles since the last taken slot or host reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         quiet_r <= 3'h0;
      end else if (slot_valid || line_reset) begin
         quiet_r <= 3'h0;
      end else if (quiet_r != 3'h7) begin
         quiet_r <= quiet_r + 3'h1;
      end
   end
   // ========
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence reset_then_gap_s;
      line_reset && ce ##1 !slot_valid ##1 !slot_valid;
   endsequence
   line_low_a: assert property (!line_o)
      else $error("line driven high");
   presence_ans_a: assert property (line_reset && ce |=> presence_req)
      else $error("no presence after reset");
   presence_cause_a: assert property ($rose(presence_req) |-> $past(line_reset))
      else $error("presence without reset");
   reset_desel_a: assert property (line_reset && ce |=> !selected)
      else $error("selection survived reset");
   reset_quiet_a: assert property (reset_then_gap_s |-> !line_oe)
      else $error("line pulled after reset");
   oe_hold_a: assert property (quiet_r >= 3'h4 |-> $stable(line_oe))
      else $error("pull changed between slots");
   sel_rise_a: assert property ($rose(selected) |-> quiet_r <= 3'h3)
      else $error("selection without a slot");
   sel_fall_a: assert property ($fell(selected) |-> quiet_r <= 3'h3)
      else $error("selection lost without cause");
   cmd_sel_a: assert property ($changed(last_cmd) && last_cmd != 8'h00 |-> $past(selected))
      else $error("function taken while unselected");
   slot_echo_a: assert property (slot_valid && ce |=> slot_done)
      else $error("slot not acknowledged");
endmodule
bind swotp_reader swotp_reader_properties chk (
   .clk_sys, .nrst, .ce, .line_reset, .slot_valid, .slot, .presence_req, .line_o, .line_oe,
   .slot_done, .selected, .mem_rd_addr, .mem_rd_data, .last_cmd
);
`default_nettype wire

/* File: tb/swotp_host_model.sv */
// Behavioural bus host framing resets and time slots for the reader
`timescale 1ns/1ps
`default_nettype none
module swotp_host_model
   import swotp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic line_o,
   input wire logic line_oe,
   output logic line_reset,
   output logic slot_valid,
   output swotp_slot_t slot
);
   logic line_lvl;
   // Pull-up holds the line high unless the reader pulls it down
   assign line_lvl = line_oe ? line_o : 1'b1;
   initial begin
      line_reset = 1'b0;
      slot_valid = 1'b0;
      slot = 2'h2;
   end
   task automatic bus_reset();
      @(negedge clk_sys);
      line_reset = 1'b1;
      @(negedge clk_sys);
      line_reset = 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask
   // One slot; read slots return the line level the reader set up
   task automatic do_slot(input logic rd, input logic wb, output logic got);
      @(negedge clk_sys);
      got = line_lvl;
      slot = {rd, wb};
      slot_valid = 1'b1;
      @(negedge clk_sys);
      slot_valid = 1'b0;
      slot = ~slot;
      repeat (5) @(negedge clk_sys);
   endtask
   task automatic put_byte(input logic [7:0] b);
      logic g;
      for (int i = 0; i < 8; i++) begin
         do_slot(1'b0, b[i], g);
      end
   endtask
   task automatic get_byte(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         do_slot(1'b1, 1'b0, b[i]);
      end
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the single-wire reader
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import swotp_pkg::*;
   localparam logic [7:0] FAM = 8'h3C; // Arbitrary value
   localparam logic [47:0] SER = 48'h5A17_C2E9_0B64; // Arbitrary value
   logic clk_sys, nrst, ce, line_reset, slot_valid, presence_req, line_o, line_oe;
   logic slot_done, selected;
   logic [7:0] mem_rd_addr, mem_rd_data, last_cmd;
   logic [63:0] id_w;
   swotp_slot_t slot;
   int err_count, n_tests;
   // ========
   // Models and checks
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic m;
      for (int i = 0; i < 8; i++) begin
         m = c[0] ^ b[i];
         c = (c >> 1) ^ (m ? 8'h8C : 8'h00);
      end
      return c;
   endfunction
   function automatic logic [7:0] id_crc();
      logic [55:0] v;
      logic [7:0] c;
      v = {SER, FAM};
      c = 8'h00;
      for (int i = 0; i < 7; i++) begin
         c = crc8(c, v[8*i +: 8]);
      end
      return c;
   endfunction
   function automatic logic [7:0] hdr_crc(input logic [7:0] lo);
      return crc8(crc8(crc8(8'h00, 8'hC3), lo), 8'h00);
   endfunction
   function automatic logic [7:0] mem_val(input logic [7:0] a);
      return {a[3:0], a[7:4]} ^ 8'h96;
   endfunction
   assign mem_rd_data = mem_val(mem_rd_addr);
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ========
   // Scenarios
   task automatic t_read_id();
      logic [7:0] b;
      host.bus_reset();
      host.put_byte(SWOTP_CMD_READ_ID);
      for (int i = 0; i < 8; i++) begin
         host.get_byte(b);
         chk8(b, id_w[8*i +: 8], "identity byte");
      end
      $display("read identity done");
   endtask
   task automatic t_match(input logic [63:0] v, input logic want);
      logic [7:0] b;
      host.bus_reset();
      host.put_byte(SWOTP_CMD_MATCH_ID);
      for (int i = 0; i < 8; i++) begin
         host.put_byte(v[8*i +: 8]);
      end
      chk8({7'h0, selected}, {7'h0, want}, "match select");
      host.put_byte(SWOTP_CMD_READ_PAGE);
      host.put_byte(8'h00);
      host.put_byte(8'h00);
      host.get_byte(b);
      chk8(b, want ? hdr_crc(8'h00) : 8'hFF, "gated header");
      $display("match identity done");
   endtask
   task automatic t_search(input int drop);
      logic t, c, g;
      host.bus_reset();
      host.put_byte(SWOTP_CMD_SEARCH_ID);
      for (int i = 0; i < 64; i++) begin
         host.do_slot(1'b1, 1'b0, t);
         host.do_slot(1'b1, 1'b0, c);
         chk8({6'h0, t, c}, (i > drop) ? 8'h03 : {6'h0, id_w[i], ~id_w[i]}, "pair");
         host.do_slot(1'b0, (i == drop) ? ~id_w[i] : id_w[i], g);
      end
      chk8({7'h0, selected}, {7'h0, drop > 63}, "search select");
      $display("search done");
   endtask
   task automatic t_page(input logic [7:0] start);
      logic [7:0] b, c, a;
      host.bus_reset();
      host.put_byte(SWOTP_CMD_SKIP_ID);
      host.put_byte(SWOTP_CMD_READ_PAGE);
      host.put_byte(start);
      host.put_byte(8'h00);
      chk8(last_cmd, SWOTP_CMD_READ_PAGE, "function latch");
      host.get_byte(b);
      chk8(b, hdr_crc(start), "header check");
      a = start;
      c = 8'h00;
      for (int n = 0; n < 40; n++) begin
         host.get_byte(b);
         if (a > SWOTP_LAST_ADDR) begin
            chk8(b, 8'hFF, "past end");
         end else begin
            chk8(b, mem_val(a), "data byte");
            c = crc8(c, mem_val(a));
            if (a[4:0] == 5'h1F) begin
               host.get_byte(b);
               chk8(b, c, "page check");
               c = 8'h00;
            end
            a = a + 8'h01;
         end
      end
      $display("paged read from %h done", start);
   endtask
   task automatic t_refuse();
      logic [7:0] b;
      logic [7:0] codes [4];
      codes = '{SWOTP_CMD_READ_FIELD, SWOTP_CMD_WRITE_DATA, SWOTP_CMD_READ_STAT,
                SWOTP_CMD_WRITE_STAT};
      foreach (codes[k]) begin
         host.bus_reset();
         chk8({7'h0, selected}, 8'h00, "reset drops select");
         host.put_byte(SWOTP_CMD_SKIP_ID);
         chk8({7'h0, selected}, 8'h01, "skip select");
         host.put_byte(codes[k]);
         host.put_byte(8'h00);
         host.put_byte(8'h00);
         host.get_byte(b);
         chk8(last_cmd, codes[k], "function code");
         chk8(b, 8'hFF, "unsupported quiet");
      end
      host.bus_reset();
      host.put_byte(8'h96);
      host.put_byte(SWOTP_CMD_READ_PAGE);
      host.get_byte(b);
      chk8(b, 8'hFF, "no identity quiet");
      chk8({7'h0, selected}, 8'h00, "no identity select");
      $display("refusals done");
   endtask
   task automatic t_freeze();
      logic [7:0] b;
      host.bus_reset();
      host.put_byte(SWOTP_CMD_SKIP_ID);
      // A host reset while frozen must leave the selection alone
      ce = 1'b0;
      host.bus_reset();
      ce = 1'b1;
      chk8({7'h0, selected}, 8'h01, "frozen select");
      host.put_byte(SWOTP_CMD_READ_PAGE);
      host.put_byte(8'h00);
      host.put_byte(8'h00);
      host.get_byte(b);
      chk8(b, hdr_crc(8'h00), "frozen header");
      $display("clock enable hold done");
   endtask
   // ========
   // Harness
   swotp_reader #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) dut (
      .clk_sys, .nrst, .ce, .line_reset, .slot_valid, .slot, .presence_req, .line_o,
      .line_oe, .slot_done, .selected, .mem_rd_addr, .mem_rd_data, .last_cmd
   );
   swotp_host_model host (
      .clk_sys, .line_o, .line_oe, .line_reset, .slot_valid, .slot
   );
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      err_count++;
      test_done();
   end
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      err_count = 0;
      n_tests = 0;
      id_w = {id_crc(), SER, FAM};
      repeat (12) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (2) @(negedge clk_sys);
      t_read_id();
      t_match(id_w, 1'b1);
      t_match(id_w ^ 64'h8000_0000_0000_0000, 1'b0);
      t_match(id_w ^ 64'h0000_0000_0000_0001, 1'b0);
      t_search(64);
      t_search(5);
      t_page(8'h1D);
      t_page(8'hBE);
      t_page(8'hC5);
      t_refuse();
      t_freeze();
      test_done();
   end
endmodule
`default_nettype wire
